// ### byte_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; read data are held in a register.
 */
`timescale 1ns/10ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
        logic [WIDTH-1:0] head;
        logic head_v;
    } fifo_st_t;
    fifo_st_t st_r, st_nxt;
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] count;
    logic [AW:0] fill;
    logic push, pop, mem_has;

    // Occupancy includes the output register, so DEPTH words in all
    assign count = st_r.wp - st_r.rp;
    assign fill = count + (AW+1)'(st_r.head_v);
    assign mem_has = count != '0;
    // Ready only when a push really lands, never a dropped word
    assign in_ready = fill < (AW+1)'(DEPTH);
    assign push = in_valid && in_ready;
    assign pop = mem_has && (!st_r.head_v || out_ready);
    assign out_valid = st_r.head_v;
    assign out_data = st_r.head;

    // Pointer and head register update
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.wp = st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = st_r.rp + 1'b1;
            st_nxt.head = mem_r[st_r.rp[AW-1:0]];
            st_nxt.head_v = 1'b1;
        end else if (out_ready) begin
            st_nxt.head_v = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Storage array
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_r[st_r.wp[AW-1:0]] <= in_data;
        end
    end
endmodule

// ### host_model.sv
/* Host processor model for the byte port.
   Assumes the port's clock; pins move only just after rising edges. */
`timescale 1ns/10ps
module host_model (
    input wire logic ref_clk,
    input wire logic [7:0] dev_out,
    input wire logic dev_oe,
    input wire logic attention,
    output logic chip_sel_n,
    output logic rd_n,
    output logic wr_n,
    output logic register_select,
    output logic upper_select,
    output logic [7:0] bus
);
    logic drv = 1'b0;
    logic [7:0] wdat = 8'h00;
    logic [7:0] last = 8'h00;
    // Strobes idle high
    initial begin
        {chip_sel_n, rd_n, wr_n, register_select, upper_select} = 5'h1c;
    end
    assign bus = dev_oe ? dev_out : (drv ? wdat : ~last);
    // Released bus toggles every cycle
    always @(posedge ref_clk) begin
        last <= bus;
    end
    // Read cycle, six edges low
    task automatic rd(input logic sel, output logic [7:0] d);
        @(posedge ref_clk);
        chip_sel_n <= 1'b0;
        rd_n <= 1'b0;
        register_select <= sel;
        repeat (6) @(posedge ref_clk);
        d = bus;
        chip_sel_n <= 1'b1;
        rd_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic wr(input logic sel, input logic [7:0] v);
        logic [7:0] s;
        s = 8'h40;
        for (int i = 0; i < 40 && s[6]; i++) rd(1'b1, s);
        @(posedge ref_clk);
        chip_sel_n <= 1'b0;
        wr_n <= 1'b0;
        register_select <= sel;
        drv <= 1'b1;
        wdat <= v;
        repeat (4) @(posedge ref_clk);
        chip_sel_n <= 1'b1;
        wr_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        drv <= 1'b0;
    endtask
    // wait pending byte, read tag, then data
    task automatic fetch(input logic poll, output logic [7:0] s, output logic [7:0] d);
        s = 8'h80;
        for (int i = 0; i < 40 && s[7]; i++) begin
            if (poll) rd(1'b1, s);
            else @(posedge ref_clk) s[7] = ~attention;
        end
        rd(1'b1, s);
        rd(1'b0, d);
    endtask
endmodule

// ### host_parallel_port.sv
/*
 * Slave side of the 8-bit host parallel port, basic mode.
 * Host strobes are asynchronous and pass two flip-flops first.
 * The control processor side loads outbound bytes with a flow tag,
 * drains inbound bytes from a 16-deep FIFO and clears the full bit.
 */
`timescale 1ns/10ps
module host_parallel_port
    import host_port_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic chip_sel_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic register_select,
    input wire logic upper_select,
    input wire logic [7:0] host_byte_bus_in,
    output logic [7:0] host_byte_bus_out,
    output logic host_byte_bus_oe,
    output logic attention,
    input wire logic [7:0] out_byte,
    input wire logic [3:0] out_tag,
    input wire logic out_load,
    output logic [8:0] in_word,
    output logic in_valid,
    input wire logic in_ready,
    input wire logic fifo_full_bit_clr,
    output logic fifo_full_bit
);
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [8:0] raw1;
        logic [8:0] raw2;
        acc_state_t acc;
        logic [7:0] out_byte;
        logic [3:0] tag;
        logic pending;
        logic [8:0] held;
        logic held_v;
        logic full_bit;
        logic [7:0] dout;
        logic oe;
    } port_st_t;
    port_st_t st_r, st_nxt;
    logic [2:0] strb;
    logic rd_act, wr_act, fifo_in_ready, push;
    logic [7:0] status_byte;

    // Status byte assembly, flags in bits 7:6 and tag in bits 3:0 per field layout
    function automatic logic [7:0] make_status(input logic pend, input logic full,
                                               input logic [3:0] tag);
        logic [7:0] s;
        s = 8'h00;
        s[STAT_EMPTY_BIT] = !pend;
        s[STAT_FULL_BIT] = full;
        s[STAT_TAG_LSB +: TAG_W] = tag;
        return s;
    endfunction

    // Decoded strobes after synchroniser, active high
    assign strb = st_r.s2;
    assign rd_act = !strb[2] && !strb[1];
    assign wr_act = !strb[2] && !strb[0];
    assign status_byte = make_status(st_r.pending, st_r.held_v || st_r.full_bit, st_r.tag);
    assign push = st_r.held_v && fifo_in_ready && !st_r.full_bit;

    // Port logic: sync, access tracking, flags
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = {chip_sel_n, rd_n, wr_n};
        st_nxt.s2 = st_r.s1;
        st_nxt.raw1 = {register_select, host_byte_bus_in};
        st_nxt.raw2 = st_r.raw1;
        if (out_load && !st_r.pending) begin
            st_nxt.out_byte = out_byte;
            st_nxt.tag = out_tag;
            st_nxt.pending = 1'b1;
        end
        if (push) begin
            st_nxt.held_v = 1'b0;
        end
        // full bit set by fifo full, cleared by processor
        if (fifo_full_bit_clr) begin
            st_nxt.full_bit = 1'b0;
        end
        if (!fifo_in_ready) begin
            st_nxt.full_bit = 1'b1;
        end
        case (st_r.acc)
            ACC_IDLE: begin
                st_nxt.oe = 1'b0;
                if (rd_act) begin
                    st_nxt.acc = ACC_READ;
                end else if (wr_act) begin
                    st_nxt.acc = ACC_WRITE;
                end
            end
            ACC_READ: begin
                st_nxt.oe = 1'b1;
                st_nxt.dout = st_r.raw2[8] ? status_byte : st_r.out_byte;
                if (!rd_act) begin
                    st_nxt.acc = ACC_IDLE;
                    st_nxt.oe = 1'b0;
                    // attention drops at data register read strobe rise, not after a status read
                    // A load in the cycle the read strobe rise is seen is ignored if a byte is still pending
                    if (!st_r.raw2[8] && st_r.pending) begin
                        st_nxt.pending = 1'b0;
                    end
                end
            end
            ACC_WRITE: begin
                // held byte keeps full flag up
                if (!wr_act) begin
                    st_nxt.acc = ACC_IDLE;
                    st_nxt.held = st_r.raw2;
                    st_nxt.held_v = 1'b1;
                end
            end
            default: begin
                st_nxt.acc = ACC_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_r <= '{s1: STROBE_IDLE, s2: STROBE_IDLE, raw1: '0, raw2: '0,
                      acc: ACC_IDLE, out_byte: BYTE_RST, tag: TAG_RST, pending: 1'b0,
                      held: '0, held_v: 1'b0, full_bit: 1'b0, dout: BYTE_RST, oe: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Inbound FIFO, word = {control flag, byte}
    byte_fifo #(.WIDTH(DATA_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .srst(srst),
        .in_data(st_r.held),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .out_data(in_word),
        .out_valid(in_valid),
        .out_ready(in_ready)
    );

    assign host_byte_bus_out = st_r.dout;
    assign host_byte_bus_oe = st_r.oe;
    assign attention = st_r.pending;
    assign fifo_full_bit = st_r.full_bit;

    a_flag_inverse: assert property (@(posedge ref_clk) disable iff (srst)
        status_byte[STAT_EMPTY_BIT] == !attention)
        else $error("empty flag disagrees with attention");
    a_attn_drop: assert property (@(posedge ref_clk) disable iff (srst)
        (st_r.acc == ACC_READ && !rd_act && !st_r.raw2[8] && attention) |=> !attention)
        else $error("attention not dropped after data read");
    a_status_read: assert property (@(posedge ref_clk) disable iff (srst)
        (st_r.acc == ACC_READ && rd_act && st_r.raw2[8]) |=> st_r.dout == $past(status_byte))
        else $error("status byte not driven");
    a_data_read: assert property (@(posedge ref_clk) disable iff (srst)
        (st_r.acc == ACC_READ && rd_act && !st_r.raw2[8]) |=> st_r.dout == $past(st_r.out_byte))
        else $error("data byte not driven");
    a_held_full: assert property (@(posedge ref_clk) disable iff (srst)
        st_r.held_v |-> status_byte[STAT_FULL_BIT])
        else $error("full flag low with held byte");
    a_fifo_full: assert property (@(posedge ref_clk) disable iff (srst)
        !fifo_in_ready |=> fifo_full_bit)
        else $error("full bit not set on full fifo");
    a_write_push: assert property (@(posedge ref_clk) disable iff (srst)
        (st_r.acc == ACC_WRITE && !wr_act) |=> st_r.held_v)
        else $error("write not captured");
    a_load_pend: assert property (@(posedge ref_clk) disable iff (srst)
        (out_load && !attention) |=> attention ##0 !status_byte[STAT_EMPTY_BIT])
        else $error("load did not raise attention");
    a_status_zero: assert property (@(posedge ref_clk) disable iff (srst)
        status_byte[5:4] == 2'b00)
        else $error("unused status bits not zero");
endmodule

// ### host_port_pkg.sv
/*
 * Shared constants for the host parallel port: status byte layout,
 * FIFO geometry, reset values and host access states.
 * Assumes a single 200 MHz system clock and a synchronous reset.
 */
package host_port_pkg;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int TAG_W = 4;
    // Status byte field positions
    localparam int STAT_EMPTY_BIT = 7;
    localparam int STAT_FULL_BIT = 6;
    localparam int STAT_TAG_LSB = 0;
    // Reset values
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [3:0] TAG_RST = 4'h0;
    localparam logic [2:0] STROBE_IDLE = 3'h7;
    // Clock period, for reference
    localparam int CLK_PERIOD_NS = 5;
    // Host access states
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_READ = 2'b01,
        ACC_WRITE = 2'b10
    } acc_state_t;
endpackage

// ### tb.sv
/* Self-checking bench for the host byte port.
   Assumes 200 MHz ref_clk and synchronous active-high srst. */
`timescale 1ns/10ps
module tb;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] out_byte = 8'h00;
    logic [3:0] out_tag = 4'h0;
    logic out_load = 1'b0;
    logic in_ready = 1'b0;
    logic fifo_full_bit_clr = 1'b0;
    wire logic chip_sel_n, rd_n, wr_n, register_select, upper_select, attention;
    wire logic [7:0] bus, dout;
    wire logic oe, in_valid, fifo_full_bit;
    wire logic [8:0] in_word;
    logic [7:0] s, d;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    int n = 0;
    host_parallel_port uut (.ref_clk(ref_clk), .srst(srst), .chip_sel_n(chip_sel_n),
        .rd_n(rd_n), .wr_n(wr_n), .register_select(register_select),
        .upper_select(upper_select), .host_byte_bus_in(bus), .host_byte_bus_out(dout),
        .host_byte_bus_oe(oe), .attention(attention), .out_byte(out_byte),
        .out_tag(out_tag), .out_load(out_load), .in_word(in_word), .in_valid(in_valid),
        .in_ready(in_ready), .fifo_full_bit_clr(fifo_full_bit_clr),
        .fifo_full_bit(fifo_full_bit));
    host_model host (.ref_clk(ref_clk), .dev_out(dout), .dev_oe(oe), .attention(attention),
        .chip_sel_n(chip_sel_n), .rd_n(rd_n), .wr_n(wr_n), .register_select(register_select),
        .upper_select(upper_select), .bus(bus));
    // Clock
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Processor loads one outbound byte
    task automatic load(input logic [7:0] b, input logic [3:0] t);
        @(posedge ref_clk);
        out_byte <= b;
        out_tag <= t;
        out_load <= 1'b1;
        @(posedge ref_clk);
        out_load <= 1'b0;
    endtask
    // Processor clears the full bit
    task automatic clr();
        @(posedge ref_clk);
        fifo_full_bit_clr <= 1'b1;
        @(posedge ref_clk);
        fifo_full_bit_clr <= 1'b0;
    endtask
    // Hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            wrap_up();
        end
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        host.rd(1'b1, s);
        chk("status", s, 8'h80);
        chk("attention", attention, 1'b0);
        load(8'ha5, 4'h9);
        @(posedge ref_clk);
        chk("attention", attention, 1'b1);
        load(8'h11, 4'h5);
        host.fetch(1'b0, s, d);
        chk("tag status", s, 8'h09);
        chk("data", d, 8'ha5);
        chk("attention", attention, 1'b0);
        host.rd(1'b1, s);
        chk("status", s, 8'h89);
        load(8'h3c, 4'hf);
        host.fetch(1'b1, s, d);
        chk("tag status", s, 8'h0f);
        chk("data", d, 8'h3c);
        for (int i = 0; i < 16; i++) host.wr(i[0], 8'h10 + i[7:0]);
        host.rd(1'b1, s);
        chk("full flag", s[6], 1'b1);
        clr();
        @(posedge ref_clk);
        chk("fifo full bit", fifo_full_bit, 1'b1);
        in_ready <= 1'b1;
        repeat (200) begin
            @(posedge ref_clk);
            if (in_valid === 1'b1) begin
                chk("word", in_word, {n[0], 8'h10 + n[7:0]});
                n++;
            end
        end
        chk("word count", n[8:0], 9'h010);
        host.rd(1'b1, s);
        chk("full flag", s[6], 1'b1);
        clr();
        host.rd(1'b1, s);
        chk("status", s, 8'h8f);
        wrap_up();
    end
endmodule
